// ===== verilog/emfm_cfg.svh
// Constants of the E1 transport frame mapper
// How it works
// - Each adapted frame carries exactly 5760 transport bytes, payload rate 1920 kbit/s.
// - Transport frame length field is 5760 bytes with this adaptation.
// - Transport bytes need no line frame alignment but each fills one whole timeslot.
// - Timeslot zero carries the sync byte, timeslot sixteen the supervision byte.
// - One adapted frame lasts 24 ms and spans 6144 byte timeslots.
// - Slot (q+phase) mod 32 is 0 sync, 16 supervision, else next transport byte.
// - Phase offset is a fixed constant between 0 and 31.
// - Bytes go out from element 0 through 6143, then the next frame starts.
// - Lowest numbered bit first, lowest addressed byte first.
// - Alignment gained on sync, then non-sync with bit 1 set, then sync again.
// - Alignment lost after three consecutive sync bytes received in error.
// - Serial output runs at the 2048 kbit/s line rate.
// - Only line frame mapping; no error correction or delay compensation.
`ifndef EMFM_CFG_SVH
`define EMFM_CFG_SVH
`define EMFM_FRAME_MS 24
`define EMFM_LINE_KBPS 2048
`define EMFM_PAYLOAD_KBPS 1920
`define EMFM_LAST_Q 13'h17ff
`define EMFM_TFL 13'h1680
`define EMFM_SYNC_POS 5'h00
`define EMFM_SUP_POS 5'h10
`define EMFM_RSV_SHIFT 4
`define EMFM_PHASE_DFLT 5'h04
`define EMFM_BIT_LAST 3'h7
`define EMFM_HALF_LAST 9'h0ff
`define EMFM_PAIR_LAST 9'h1ff
`define EMFM_FAS_PAT 8'hd8
`define EMFM_FAS_MASK 8'hfe
`define EMFM_NFAS_BIT 1
`define EMFM_LOSS_LIMIT 2'h3
`define EMFM_FILL_BYTE 8'hff
`define EMFM_FIFO_DEPTH 4
`endif

// ===== verilog/emfm_pkg.sv
// Types shared by the E1 transport frame mapper
package emfm_pkg;
	// One transport byte on its way to the line
	typedef struct packed {
		logic [7:0] data;
	} emfm_byte_t;
	// Receive alignment status pair
	typedef struct packed {
		logic aligned;
		logic lost;
	} emfm_align_t;
	// Receive alignment hunt states
	typedef enum logic [1:0] {
		RX_HUNT,
		RX_NFAS,
		RX_FAS2,
		RX_LOCK
	} emfm_rx_state_t;
endpackage : emfm_pkg

// ===== verilog/emfm_mapper.sv
// E1 transport frame mapper: payload FIFO, line framer and receive alignment
`timescale 1ns/1ps
`include "emfm_cfg.svh"

module emfm_fifo
	import emfm_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = `EMFM_FIFO_DEPTH
) (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic next_in_ready, next_out_valid, push, pop;

	// Pointer arithmetic wraps at any depth, not only powers of two
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign out_data_out = mem[rd_ptr];

	// Flags are registered so the ready seen upstream is a flop
	always_comb begin
		push = in_valid_in && in_ready_out;
		pop = out_valid_out && out_ready_in;
		next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
		next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
		next_in_ready = next_count != (AW+1)'(DEPTH);
		next_out_valid = next_count != '0;
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_out <= 1'b1;
			out_valid_out <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			in_ready_out <= next_in_ready;
			out_valid_out <= next_out_valid;
		end
	end

	// Storage has no reset; only written words are ever read
	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end
endmodule : emfm_fifo

module emfm_mapper
	import emfm_pkg::*;
#(
	parameter logic [4:0] PHASE = `EMFM_PHASE_DFLT
) (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire emfm_byte_t payload_in,
	input wire logic payload_valid_in,
	output logic payload_ready_out,
	input wire logic [7:0] line_frame_sync_byte_in,
	input wire logic [7:0] line_supervision_byte_in,
	input wire logic line_clk_in,
	input wire logic line_rx_data_in,
	output logic line_tx_data_out,
	output logic frame_start_out,
	output logic underrun_out,
	output emfm_align_t align_out,
	output logic [12:0] transport_frame_length_out
);
	// All checks below run on the system clock and sleep while in reset
	default clocking cb_sys @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	// Payload buffer between the transport source and the framer
	emfm_byte_t fifo_data;
	logic fifo_valid, pop, fifo_ready;

	emfm_fifo #(
		.WIDTH($bits(emfm_byte_t)),
		.DEPTH(`EMFM_FIFO_DEPTH)
	) u_fifo (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.in_data_in(payload_in),
		.in_valid_in(payload_valid_in),
		.in_ready_out(fifo_ready),
		.out_data_out(fifo_data),
		.out_valid_out(fifo_valid),
		.out_ready_in(pop)
	);
	assign payload_ready_out = fifo_ready;

	// Line clock and receive data pass two flops before use
	logic clk_m, clk_s, clk_d, rxd_m, rxd_s, rise;
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clk_m <= 1'b0;
			clk_s <= 1'b0;
			clk_d <= 1'b0;
			rxd_m <= 1'b0;
			rxd_s <= 1'b0;
		end else begin
			clk_m <= line_clk_in;
			clk_s <= clk_m;
			clk_d <= clk_s;
			rxd_m <= line_rx_data_in;
			rxd_s <= rxd_m;
		end
	end
	// Every bit rides one line clock edge, so rate follows the line
	assign rise = clk_s && !clk_d;

	// Slot position within a line frame, phase shifted
	function automatic logic [4:0] slot_pos(input logic [12:0] q);
		slot_pos = q[4:0] + PHASE;
	endfunction : slot_pos
	// Transmit framer state
	logic [12:0] q, next_q, pay_cnt, next_pay_cnt;
	logic [2:0] bit_cnt, next_bit_cnt;
	logic [7:0] tx_sr, next_tx_sr, load_byte;
	logic next_tx_data, next_frame_start, next_underrun, load;
	logic [4:0] pos;
	// Byte selection and serialiser
	always_comb begin
		pos = slot_pos(q);
		load = rise && (bit_cnt == '0);
		pop = 1'b0;
		unique case (pos)
			`EMFM_SYNC_POS: load_byte = line_frame_sync_byte_in;
			`EMFM_SUP_POS: load_byte = line_supervision_byte_in;
			default: begin
				// Payload slots take the next transport byte whole
				load_byte = fifo_valid ? fifo_data.data : `EMFM_FILL_BYTE;
				pop = load && fifo_valid;
			end
		endcase
		next_q = q;
		next_bit_cnt = bit_cnt;
		next_tx_sr = tx_sr;
		next_tx_data = line_tx_data_out;
		next_pay_cnt = pay_cnt;
		next_frame_start = 1'b0;
		next_underrun = 1'b0;
		if (rise) begin
			next_bit_cnt = bit_cnt + 3'h1;
			if (load) begin
				// Lowest numbered bit leaves first
				next_tx_data = load_byte[0];
				next_tx_sr = {1'b0, load_byte[7:1]};
				next_frame_start = q == '0;
				if (pos != `EMFM_SYNC_POS && pos != `EMFM_SUP_POS) begin
					next_pay_cnt = ((q == '0) ? 13'h0 : pay_cnt) + 13'h1;
					next_underrun = !fifo_valid;
				end else if (q == '0) begin
					next_pay_cnt = '0;
				end
			end else begin
				next_tx_data = tx_sr[0];
				next_tx_sr = {1'b0, tx_sr[7:1]};
			end
			if (bit_cnt == `EMFM_BIT_LAST) begin
				// Array read in order, wrapping after the last element
				next_q = (q == `EMFM_LAST_Q) ? '0 : q + 13'h1;
			end
		end
	end

	// Framer registers; no coding or delay stage is added here
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			q <= '0;
			bit_cnt <= '0;
			tx_sr <= '0;
			pay_cnt <= '0;
			line_tx_data_out <= 1'b1;
			frame_start_out <= 1'b0;
			underrun_out <= 1'b0;
			transport_frame_length_out <= '0;
		end else begin
			q <= next_q;
			bit_cnt <= next_bit_cnt;
			tx_sr <= next_tx_sr;
			pay_cnt <= next_pay_cnt;
			line_tx_data_out <= next_tx_data;
			frame_start_out <= next_frame_start;
			underrun_out <= next_underrun;
			transport_frame_length_out <= `EMFM_TFL;
		end
	end

	// Receive alignment state
	emfm_rx_state_t rx_state, next_rx_state;
	logic [7:0] rx_sr, next_rx_sr;
	logic [8:0] rx_cnt, next_rx_cnt;
	logic [1:0] err_cnt, next_err_cnt;
	emfm_align_t next_align;
	logic fas_hit, chk_half, chk_pair;

	// Hunt, confirm and hold alignment on the received bit stream
	always_comb begin
		next_rx_sr = rise ? {rxd_s, rx_sr[7:1]} : rx_sr;
		fas_hit = (next_rx_sr & `EMFM_FAS_MASK) == `EMFM_FAS_PAT;
		chk_half = rise && rx_cnt == `EMFM_HALF_LAST;
		chk_pair = rise && rx_cnt == `EMFM_PAIR_LAST;
		next_rx_state = rx_state;
		next_rx_cnt = rise ? rx_cnt + 9'h1 : rx_cnt;
		next_err_cnt = err_cnt;
		next_align.aligned = align_out.aligned;
		next_align.lost = 1'b0;
		unique case (rx_state)
			RX_HUNT: begin
				if (rise && fas_hit) begin
					next_rx_state = RX_NFAS;
					next_rx_cnt = '0;
				end
			end
			RX_NFAS: begin
				if (chk_half) begin
					// Next frame must lack sync and carry bit 1 high
					if (!fas_hit && next_rx_sr[`EMFM_NFAS_BIT]) begin
						next_rx_state = RX_FAS2;
					end else begin
						next_rx_state = RX_HUNT;
					end
				end
			end
			RX_FAS2: begin
				if (chk_pair) begin
					next_rx_state = fas_hit ? RX_LOCK : RX_HUNT;
					next_align.aligned = fas_hit;
					next_err_cnt = '0;
				end
			end
			RX_LOCK: begin
				if (chk_pair) begin
					if (fas_hit) begin
						next_err_cnt = '0;
					end else if (err_cnt + 2'h1 == `EMFM_LOSS_LIMIT) begin
						// Third bad sync byte in a row drops alignment
						next_rx_state = RX_HUNT;
						next_align.aligned = 1'b0;
						next_align.lost = 1'b1;
						next_err_cnt = '0;
					end else begin
						next_err_cnt = err_cnt + 2'h1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rx_state <= RX_HUNT;
			rx_sr <= '0;
			rx_cnt <= '0;
			err_cnt <= '0;
			align_out <= '0;
		end else begin
			rx_state <= next_rx_state;
			rx_sr <= next_rx_sr;
			rx_cnt <= next_rx_cnt;
			err_cnt <= next_err_cnt;
			align_out <= next_align;
		end
	end

	// Checks on the framer and the alignment machine
	sequence s_byte_load;
		load;
	endsequence
	sequence s_last_bit;
		rise && bit_cnt == `EMFM_BIT_LAST;
	endsequence
	property p_q_range;
		q <= `EMFM_LAST_Q;
	endproperty
	a_q_range: assert property (p_q_range) else $error("byte index beyond frame");
	property p_sync_slot;
		s_byte_load and (pos == `EMFM_SYNC_POS) |=>
			line_tx_data_out == $past(line_frame_sync_byte_in[0]) && !pop;
	endproperty
	a_sync_slot: assert property (p_sync_slot) else $error("sync slot wrong");
	property p_sup_slot;
		s_byte_load and (pos == `EMFM_SUP_POS) |=>
			line_tx_data_out == $past(line_supervision_byte_in[0]);
	endproperty
	a_sup_slot: assert property (p_sup_slot) else $error("supervision slot wrong");
	property p_pop_payload;
		pop |-> load && pos != `EMFM_SYNC_POS && pos != `EMFM_SUP_POS;
	endproperty
	a_pop_payload: assert property (p_pop_payload) else $error("payload popped off slot");
	// A whole frame is too long to watch often, so the rate is also held per line frame
	property p_slot_count;
		s_byte_load and (q[4:0] == '0) and (q != '0) |-> pay_cnt == q - (q >> `EMFM_RSV_SHIFT);
	endproperty
	a_slot_count: assert property (p_slot_count) else $error("payload rate wrong");
	property p_frame_payload;
		s_byte_load and (q == '0) and (pay_cnt != '0) |-> pay_cnt == `EMFM_TFL;
	endproperty
	a_frame_payload: assert property (p_frame_payload) else $error("payload count wrong");
	property p_next_bit;
		rise && !load |=> line_tx_data_out == $past(tx_sr[0]);
	endproperty
	a_next_bit: assert property (p_next_bit) else $error("bit order wrong");
	property p_q_advance;
		s_last_bit |=> q == (($past(q) == `EMFM_LAST_Q) ? 13'h0 : $past(q) + 13'h1);
	endproperty
	a_q_advance: assert property (p_q_advance) else $error("array order broken");
	property p_lock_gain;
		rx_state == RX_FAS2 && chk_pair && fas_hit |=> align_out.aligned && rx_state == RX_LOCK;
	endproperty
	a_lock_gain: assert property (p_lock_gain) else $error("alignment not declared");
	property p_lock_loss;
		rx_state == RX_LOCK && chk_pair && !fas_hit && err_cnt == 2'h2 |=>
			align_out.lost && !align_out.aligned ##1 !align_out.lost;
	endproperty
	a_lock_loss: assert property (p_lock_loss) else $error("alignment loss missed");
	property p_len;
		frame_start_out |-> transport_frame_length_out == `EMFM_TFL;
	endproperty
	a_len: assert property (p_len) else $error("frame length field wrong");
endmodule : emfm_mapper

// ===== verif/emfm_line_model.sv
// Line side model: bit clock, receive framing words, transmit capture
`timescale 1ns/1ps
module emfm_line_model (
	input wire logic go_in,
	input wire logic corrupt_in,
	input wire logic tx_in,
	output logic lclk_out,
	output logic rx_out,
	output int fas_out
);
	logic [7:0] cap [0:95];
	logic [7:0] sh;
	logic [7:0] rbyte;
	logic rx = 1'b0;
	logic odd = 1'b0;
	int cap_n = 0;
	int nrise = 0;
	int rb = 0;
	int fas_n = 0;
	assign rx_out = rx;
	assign fas_out = fas_n;
	// Bit clock stands still until the run starts
	initial begin
		lclk_out = 1'b0;
		forever begin
			if (go_in) begin
				#80 lclk_out = 1'b1;
				#80 lclk_out = 1'b0;
			end else begin
				#20;
			end
		end
	end
	// Alignment word and non-alignment word in turn, 256 bits apart
	always @(negedge lclk_out) begin
		if (rb == 0) begin
			rbyte = odd ? 8'h02 : (corrupt_in ? 8'h00 : 8'hd8);
			if (!odd) fas_n++;
			odd = !odd;
		end else if (rb % 8 == 0) begin
			rbyte = 8'h55;
		end
		rx = rbyte[rb % 8];
		rb = (rb + 1) % 256;
	end
	// Bit k is still on the pin at rise k+1, so the first sample is dropped
	always @(posedge lclk_out) begin
		if (nrise > 0) begin
			sh = {tx_in, sh[7:1]};
			if (nrise % 8 == 0 && cap_n < 96) begin
				cap[cap_n] = sh;
				cap_n++;
			end
		end
		nrise++;
	end
endmodule : emfm_line_model

// ===== verif/testbench.sv
// Self-checking bench for the E1 transport frame mapper
`timescale 1ns/1ps
`include "emfm_cfg.svh"
module testbench;
	import emfm_pkg::*;
	localparam int PH = 4;
	logic clk, rst_n, go, corrupt, lclk, rx, tx, rdy, fstart, under;
	logic pv = 1'b0;
	logic lost_al = 1'b1;
	logic [7:0] sync_b, sup_b;
	logic [12:0] transport_frame_length;
	emfm_byte_t pay = '0;
	emfm_align_t al;
	int fas_n, err_count, checked;
	int feed_goal = 0;
	int n_sent = 0;
	int n_fs = 0;
	int n_under = 0;
	int n_lost = 0;
	emfm_mapper #(.PHASE(5'h04)) i_dut (
		.ref_clk_in(clk),
		.reset_n_in(rst_n),
		.payload_in(pay),
		.payload_valid_in(pv),
		.payload_ready_out(rdy),
		.line_frame_sync_byte_in(sync_b),
		.line_supervision_byte_in(sup_b),
		.line_clk_in(lclk),
		.line_rx_data_in(rx),
		.line_tx_data_out(tx),
		.frame_start_out(fstart),
		.underrun_out(under),
		.align_out(al),
		.transport_frame_length_out(transport_frame_length)
	);
	emfm_line_model i_line (
		.go_in(go),
		.corrupt_in(corrupt),
		.tx_in(tx),
		.lclk_out(lclk),
		.rx_out(rx),
		.fas_out(fas_n)
	);
	// System clock, 20 ns
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Pulse counters; each pulse stands one cycle
	always @(posedge clk) begin
		if (fstart === 1'b1) n_fs++;
		if (under === 1'b1) n_under++;
		if (al.lost === 1'b1) begin
			n_lost++;
			lost_al = al.aligned;
		end
	end
	// Payload source, counting bytes from 0, stops once feed_goal bytes are taken
	always @(posedge clk) begin
		if (pv && rdy) begin
			pay.data <= pay.data + 8'h01;
			n_sent <= n_sent + 1;
		end
		pv <= (feed_goal > n_sent + ((pv && rdy) ? 1 : 0));
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude
	// A wait that ran out counts as a mismatch and ends the run
	task automatic tmo();
		chk(16'h0000, 16'h0001);
		conclude();
	endtask : tmo
	task automatic wait_fas(input int k);
		int i, s;
		s = fas_n;
		for (i = 0; i < 4500 * k && fas_n < s + k; i++) @(posedge clk);
		if (i == 4500 * k) tmo();
	endtask : wait_fas
	task automatic t_reset();
		repeat (10) @(posedge clk);
		#1;
		chk(tx, 1'b1);
		chk(rdy, 1'b1);
		chk(al, 2'h0);
		chk(transport_frame_length, 13'h0000);
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(transport_frame_length, `EMFM_TFL);
		$display("test reset done");
	endtask : t_reset
	// Line clock still stopped, so the buffer must fill and refuse
	task automatic t_fill();
		int i;
		feed_goal <= 80;
		for (i = 0; i < 50 && rdy !== 1'b0; i++) @(posedge clk);
		if (i == 50) tmo();
		#1;
		chk(pay.data, 8'h04);
		repeat (10) @(posedge clk);
		#1;
		chk(pay.data, 8'h04);
		chk(rdy, 1'b0);
		$display("test fill done");
	endtask : t_fill
	// 80 payload bytes then starvation; fill bytes expected after that
	task automatic t_map();
		int q, i, pos, ord;
		logic [7:0] e;
		go <= 1'b1;
		for (i = 0; i < 8000 && i_line.cap_n < 96; i++) @(posedge clk);
		if (i == 8000) tmo();
		chk(n_fs, 1);
		chk(n_under, 10);
		for (q = 0; q < 96; q++) begin
			pos = (q + PH) % 32;
			ord = q - (q + PH) / 16;
			e = (ord < 80) ? ord[7:0] : `EMFM_FILL_BYTE;
			if (pos == 0) e = sync_b;
			if (pos == 16) e = sup_b;
			chk(i_line.cap[q], e);
		end
		$display("test map done");
	endtask : t_map
	task automatic t_align();
		int i;
		for (i = 0; i < 20000 && al.aligned !== 1'b1; i++) @(posedge clk);
		if (i == 20000) tmo();
		chk(n_lost, 0);
		// Two bad words in a row must not drop alignment
		wait_fas(1);
		corrupt <= 1'b1;
		wait_fas(2);
		corrupt <= 1'b0;
		wait_fas(1);
		repeat (200) @(posedge clk);
		chk(al.aligned, 1'b1);
		chk(n_lost, 0);
		corrupt <= 1'b1;
		wait_fas(3);
		corrupt <= 1'b0;
		for (i = 0; i < 300 && n_lost == 0; i++) @(posedge clk);
		if (i == 300) tmo();
		chk(n_lost, 1);
		chk(lost_al, 1'b0);
		for (i = 0; i < 20000 && al.aligned !== 1'b1; i++) @(posedge clk);
		if (i == 20000) tmo();
		chk(al.aligned, 1'b1);
		$display("test align done");
	endtask : t_align
	// Time-zero values, then the scenarios
	initial begin
		rst_n = 1'b0;
		go = 1'b0;
		corrupt = 1'b0;
		sync_b = 8'h9b;
		sup_b = 8'h3c;
		err_count = 0;
		checked = 0;
		t_reset();
		t_fill();
		t_map();
		t_align();
		conclude();
	end
endmodule : testbench
